//--- core/bps_sequencer.sv
// gate drive sequencing and protection for a synchronous buck controller

// Operation
// - zero current: low drive off till next on
// - on time kept full length in light load
// - enable low: drives off, discharge on
// - dead time both transitions, never overlap
// - power good held low until ramp done
// - power good rises after 1 ms in window
// - power good drops 2 us outside wide window
// - power good is open drain, pulls low only
// - off state extended while valley current high
// - over 120% latches high off low on
// - below 70% starts undervoltage counter
// - 1 ms undervoltage latches both drives off
// - undervoltage ignored 1.2 ms after enable
// - supply lockout stops switching, auto resume
// - over temperature stops switching, auto resume
// - enable starts 750 us reference ramp
// - loop compare ends off period, then on
module bps_sequencer #(
  parameter int SS_CYC    = bps_pkg::SS_RAMP_CYC,
  parameter int PGQ_CYC   = bps_pkg::PG_QUAL_CYC,
  parameter int UVD_CYC   = bps_pkg::UV_DELAY_CYC,
  parameter int UVB_CYC   = bps_pkg::UV_BLANK_CYC,
  parameter int DEAD_C    = bps_pkg::DEAD_CYC,
  parameter int REF_W     = 10
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic                enable,
  input  wire logic                supply_lockout,
  input  wire logic                over_temp,
  input  wire bps_pkg::bps_fb_cmp_t fb_cmp,
  input  wire logic                loop_set,
  input  wire logic                on_time_done,
  input  wire logic                zero_cross_detect,
  input  wire logic                valley_current_limit,
  output logic                     high_gate_drive,
  output logic                     low_gate_drive,
  output logic                     discharge_on,
  output logic                     on_time_start,
  output logic [REF_W-1:0]         ref_level,
  output logic                     soft_start_done,
  output logic                     power_good_flag_oe,
  output logic                     power_good_flag_out,
  output logic                     overvoltage_latch,
  output logic                     undervoltage_fault
);

  typedef enum logic [2:0] {
    BPS_IDLE, BPS_DEAD_TO_HIGH, BPS_HIGH_ON, BPS_DEAD_TO_LOW, BPS_LOW_ON, BPS_BOTH_OFF
  } bps_state_t;

  localparam int SSW = $clog2(SS_CYC + 1);
  localparam int PDW = $clog2(bps_pkg::PG_DROP_CYC + 1);
  localparam int DW  = $clog2(DEAD_C + 1);

  if (SS_CYC < 1 || DEAD_C < 1 || REF_W < 2) begin
    $error("bps_sequencer: bad parameter");
  end

  // ----------------------------------------------------------------
  // run qualification
  // ----------------------------------------------------------------
  logic stop_now;
  logic hold_fault;
  logic ss_done;
  assign stop_now   = !enable || supply_lockout || over_temp;
  assign hold_fault = overvoltage_latch || undervoltage_fault;

  // ----------------------------------------------------------------
  // soft start ramp
  // ----------------------------------------------------------------
  logic [SSW-1:0] ss_cnt_ff;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ss_cnt_ff <= '0;
    end else if (clk_en) begin
      if (!enable) begin
        ss_cnt_ff <= '0;
      end else if (ss_cnt_ff != SSW'(SS_CYC)) begin
        ss_cnt_ff <= ss_cnt_ff + SSW'(1);
      end
    end
  end
  assign ss_done = (ss_cnt_ff == SSW'(SS_CYC));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_level       <= '0;
      soft_start_done <= 1'b0;
    end else if (clk_en) begin
      ref_level       <= REF_W'((64'(ss_cnt_ff) * ((64'd1 << REF_W) - 1)) / SS_CYC);
      soft_start_done <= ss_done;
    end
  end

  // ----------------------------------------------------------------
  // undervoltage blanking and delay
  // ----------------------------------------------------------------
  logic uv_blank_end;
  logic uv_expired;
  bps_delay_timer #(.COUNT(UVB_CYC)) u_uv_blank (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .cond    (enable),
    .expired (uv_blank_end)
  );
  bps_delay_timer #(.COUNT(UVD_CYC)) u_uv_delay (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .cond    (fb_cmp.under_70 && uv_blank_end),
    .expired (uv_expired)
  );

  // ----------------------------------------------------------------
  // fault latches
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      overvoltage_latch  <= 1'b0;
      undervoltage_fault <= 1'b0;
    end else if (clk_en) begin
      if (!enable || supply_lockout) begin
        overvoltage_latch  <= 1'b0;
        undervoltage_fault <= 1'b0;
      end else begin
        if (fb_cmp.over_120) overvoltage_latch <= 1'b1;
        if (uv_expired) undervoltage_fault <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power good
  // ----------------------------------------------------------------
  logic pg_qual;
  logic [PDW-1:0] pg_drop_ff;
  logic pg_ff;
  bps_delay_timer #(.COUNT(PGQ_CYC)) u_pg_qual (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .cond    (fb_cmp.in_pg_window && ss_done && !stop_now),
    .expired (pg_qual)
  );
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pg_ff      <= 1'b0;
      pg_drop_ff <= '0;
    end else if (clk_en) begin
      if (!ss_done || stop_now || hold_fault) begin
        pg_ff      <= 1'b0;
        pg_drop_ff <= '0;
      end else if (!pg_ff) begin
        pg_ff      <= pg_qual;
        pg_drop_ff <= '0;
      end else if (!fb_cmp.out_wide_window) begin
        pg_drop_ff <= '0;
      end else if (pg_drop_ff == PDW'(bps_pkg::PG_DROP_CYC - 1)) begin
        pg_ff      <= 1'b0;
        pg_drop_ff <= '0;
      end else begin
        pg_drop_ff <= pg_drop_ff + PDW'(1);
      end
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      power_good_flag_oe  <= 1'b1;
      power_good_flag_out <= 1'b0;
    end else if (clk_en) begin
      power_good_flag_oe  <= !pg_ff;
      power_good_flag_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // gate drive state machine
  // ----------------------------------------------------------------
  bps_state_t st_ff;
  logic [DW-1:0] dead_ff;
  logic dead_done;
  assign dead_done = (dead_ff == DW'(DEAD_C));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dead_ff <= '0;
    end else if (clk_en) begin
      if (st_ff == BPS_DEAD_TO_HIGH || st_ff == BPS_DEAD_TO_LOW) begin
        if (!dead_done) dead_ff <= dead_ff + DW'(1);
      end else begin
        dead_ff <= '0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= BPS_IDLE;
    end else if (clk_en) begin
      if (stop_now || undervoltage_fault) begin
        st_ff <= BPS_IDLE;
      end else if (overvoltage_latch) begin
        st_ff <= (st_ff == BPS_HIGH_ON) ? BPS_DEAD_TO_LOW :
                 (st_ff == BPS_DEAD_TO_LOW && dead_done) ? BPS_LOW_ON :
                 (st_ff == BPS_DEAD_TO_LOW) ? BPS_DEAD_TO_LOW : BPS_LOW_ON;
      end else begin
        case (st_ff)
          BPS_IDLE: begin
            if (loop_set && !valley_current_limit) st_ff <= BPS_DEAD_TO_HIGH;
          end
          BPS_DEAD_TO_HIGH: begin
            if (dead_done) st_ff <= BPS_HIGH_ON;
          end
          BPS_HIGH_ON: begin
            if (on_time_done) st_ff <= BPS_DEAD_TO_LOW;
          end
          BPS_DEAD_TO_LOW: begin
            if (dead_done) st_ff <= BPS_LOW_ON;
          end
          BPS_LOW_ON: begin
            if (zero_cross_detect) st_ff <= BPS_BOTH_OFF;
            else if (loop_set && !valley_current_limit) st_ff <= BPS_DEAD_TO_HIGH;
          end
          BPS_BOTH_OFF: begin
            if (loop_set && !valley_current_limit) st_ff <= BPS_DEAD_TO_HIGH;
          end
          default: st_ff <= BPS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registered drive outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      high_gate_drive <= 1'b0;
      low_gate_drive  <= 1'b0;
      discharge_on    <= 1'b0;
      on_time_start   <= 1'b0;
    end else if (clk_en) begin
      high_gate_drive <= (st_ff == BPS_HIGH_ON) && !stop_now && !hold_fault;
      low_gate_drive  <= (st_ff == BPS_LOW_ON) && !stop_now && !undervoltage_fault;
      discharge_on    <= !enable;
      on_time_start   <= (st_ff == BPS_DEAD_TO_HIGH) && dead_done && !stop_now && !hold_fault;
    end
  end

endmodule

//--- core/bps_pkg.sv
// shared constants and carrier types for the buck protection sequencer
package bps_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 125;
  localparam int SS_RAMP_US    = 750;
  localparam int PG_QUAL_US    = 1000;
  localparam int PG_DROP_NS    = 2000;
  localparam int UV_DELAY_US   = 1000;
  localparam int UV_BLANK_US   = 1200;
  localparam int DEAD_NS       = 24;
  localparam int SS_RAMP_CYC   = SS_RAMP_US * CLK_MHZ;
  localparam int PG_QUAL_CYC   = PG_QUAL_US * CLK_MHZ;
  localparam int PG_DROP_CYC   = (PG_DROP_NS * CLK_MHZ) / 1000;
  localparam int UV_DELAY_CYC  = UV_DELAY_US * CLK_MHZ;
  localparam int UV_BLANK_CYC  = UV_BLANK_US * CLK_MHZ;
  localparam int DEAD_CYC      = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic in_pg_window;     // inside +10%/-5%
    logic out_wide_window;  // outside +15%/-10%
    logic over_120;
    logic under_70;
  } bps_fb_cmp_t;

  typedef struct packed {
    logic high_gate_drive;
    logic low_gate_drive;
    logic discharge_on;
  } bps_drive_t;

endpackage

//--- core/bps_delay_timer.sv
// qualification timer: output rises after input held high for a count
module bps_delay_timer #(
  parameter int COUNT = 125
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic cond,
  output logic      expired
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_ff;

  if (COUNT < 1) begin
    $error("bps_delay_timer: COUNT must be at least 1");
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (!cond) begin
        cnt_ff <= '0;
      end else if (cnt_ff != W'(COUNT)) begin
        cnt_ff <= cnt_ff + W'(1);
      end
    end
  end

  assign expired = (cnt_ff == W'(COUNT));
endmodule

//--- bench/bps_sequencer_sva.sv
// assertion checker for the buck protection sequencer
module bps_sva (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic                 clk_en,
  input wire logic                 enable,
  input wire logic                 supply_lockout,
  input wire logic                 over_temp,
  input wire bps_pkg::bps_fb_cmp_t fb_cmp,
  input wire logic                 zero_cross_detect,
  input wire logic                 high_gate_drive,
  input wire logic                 low_gate_drive,
  input wire logic                 discharge_on,
  input wire logic                 on_time_start,
  input wire logic                 soft_start_done,
  input wire logic                 power_good_flag_oe,
  input wire logic                 power_good_flag_out,
  input wire logic                 overvoltage_latch,
  input wire logic                 undervoltage_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // drive and fault relations
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_no_overlap: assert property (!(high_gate_drive && low_gate_drive))
    else $error("both drives on");
  a_dead_low: assert property ($fell(high_gate_drive) |-> !low_gate_drive [*3])
    else $error("low drive rose inside dead time");
  a_zero_cross: assert property (clk_en && low_gate_drive && zero_cross_detect
    && !overvoltage_latch |-> ##[1:2] !low_gate_drive) else $error("low drive kept on");
  a_off_disable: assert property ((clk_en && !enable) [*2] |=>
    !high_gate_drive && !low_gate_drive && discharge_on) else $error("disable not honoured");
  a_pg_softstart: assert property (!soft_start_done |-> power_good_flag_oe)
    else $error("power good before ramp end");
  a_pg_open_drain: assert property (!power_good_flag_out)
    else $error("power good driven high");
  a_ov_latch: assert property (clk_en && enable && !supply_lockout && fb_cmp.over_120
    |=> overvoltage_latch) else $error("overvoltage not latched");
  a_ov_high_off: assert property (overvoltage_latch [*3] |-> !high_gate_drive)
    else $error("high drive on in overvoltage");
  a_uv_drives_off: assert property (undervoltage_fault [*2] |->
    !high_gate_drive && !low_gate_drive) else $error("drive on in undervoltage");
  a_stop_off: assert property ((clk_en && (supply_lockout || over_temp)) [*2] |=>
    !high_gate_drive && !low_gate_drive) else $error("switching while stopped");
  a_fault_clear: assert property (clk_en && (!enable || supply_lockout) |=>
    !overvoltage_latch && !undervoltage_fault) else $error("fault not cleared");
  a_on_start: assert property (clk_en && on_time_start && enable && !supply_lockout
    && !over_temp && !overvoltage_latch && !undervoltage_fault |=> high_gate_drive)
    else $error("high drive missing after start");
  c_pg_up: cover property ($fell(power_good_flag_oe));
  c_ov: cover property ($rose(overvoltage_latch));
  c_uv: cover property ($rose(undervoltage_fault));
endmodule

bind bps_sequencer bps_sva u_sva (.*);

//--- bench/bps_power_stage.sv
// power stage stand-in: on-time source, loop compare, zero cross, pull-up
module bps_power_stage #(
  parameter int ON_T  = 5,
  parameter int OFF_T = 12,
  parameter int ZC_T  = 2
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic dcm,
  input  wire logic high_gate_drive,
  input  wire logic low_gate_drive,
  input  wire logic power_good_flag_oe,
  input  wire logic power_good_flag_out,
  output logic      on_time_done,
  output logic      loop_set,
  output logic      zero_cross_detect,
  output logic      pg_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int hi_cnt;
  int off_cnt;
  int lo_cnt;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt <= 0;
      off_cnt <= 0;
      lo_cnt <= 0;
    end else begin
      hi_cnt <= high_gate_drive ? hi_cnt + 1 : 0;
      off_cnt <= high_gate_drive ? 0 : off_cnt + 1;
      lo_cnt <= low_gate_drive ? lo_cnt + 1 : 0;
    end
  end
  assign on_time_done = hi_cnt >= ON_T;
  assign loop_set = off_cnt >= OFF_T;
  assign zero_cross_detect = dcm && lo_cnt >= ZC_T;
  // external pull-up on the open-drain flag
  assign pg_pin = power_good_flag_oe ? power_good_flag_out : 1'h1;
endmodule

//--- bench/testbench.sv
// self-checking bench for the buck protection sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS = 20, PGQ = 16, UVD = 10, UVB = 12, DC = 3, ON_T = 5, ZC_T = 2;
  logic clock = 0, sys_rst = 1, clk_en = 1, enable = 0, supply_lockout = 0, over_temp = 0;
  logic valley_current_limit = 0, dcm = 0;
  bps_pkg::bps_fb_cmp_t fb_cmp = '0;
  logic high_gate_drive, low_gate_drive, discharge_on, on_time_start, soft_start_done;
  logic power_good_flag_oe, power_good_flag_out, overvoltage_latch, undervoltage_fault;
  logic on_time_done, loop_set, zero_cross_detect, pg_pin;
  logic [9:0] ref_level;
  int n_fail = 0, n_tests = 0, c, w;
  always #4 clock = ~clock;
  bps_sequencer #(.SS_CYC(SS), .PGQ_CYC(PGQ), .UVD_CYC(UVD), .UVB_CYC(UVB), .DEAD_C(DC)) DUT (.*);
  bps_power_stage #(.ON_T(ON_T), .ZC_T(ZC_T)) u_ps (.*);
  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function logic pick(int s);
    case (s)
      0: pick = high_gate_drive;
      1: pick = low_gate_drive;
      2: pick = power_good_flag_oe;
      3: pick = soft_start_done;
      default: pick = undervoltage_fault;
    endcase
  endfunction
  // counts falling edges until the chosen output takes the value
  task wt(input int s, input logic v);
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while (pick(s) !== v && c < 1000);
  endtask
  initial begin
    #100000;
    n_fail++;
    results;
  end
  // ----
  // reference model of the fault latches
  // ----
  int m_blank = 0, m_uvd = 0;
  logic m_ov = 0, m_uv = 0;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      m_blank = 0;
      m_uvd = 0;
      m_ov = 0;
      m_uv = 0;
    end else if (clk_en) begin
      if (!enable || supply_lockout) begin
        m_ov = 0;
        m_uv = 0;
      end else begin
        m_ov = m_ov || fb_cmp.over_120;
        m_uv = m_uv || (m_uvd == UVD);
      end
      m_uvd = (fb_cmp.under_70 && m_blank == UVB) ? m_uvd + (m_uvd < UVD) : 0;
      m_blank = enable ? m_blank + (m_blank < UVB) : 0;
    end
  end
  always @(negedge clock) begin
    if (!sys_rst) begin
      check({overvoltage_latch, undervoltage_fault}, {m_ov, m_uv});
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(38175));
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    repeat (2) @(negedge clock);
    check(pg_pin, 0);
    check({high_gate_drive, low_gate_drive, discharge_on}, 3'h1);
    @(posedge clock) enable <= 1;
    wt(3, 1);
    check(c >= SS, 1);
    check(ref_level, 10'h3ff);
    for (int m = 0; m < 2; m++) begin
      @(posedge clock) dcm <= m[0];
      wt(0, 0);
      wt(0, 1);
      wt(0, 0);
      check(c, ON_T + 2);
      wt(1, 1);
      check(c, DC + 1);
      wt(1, 0);
      if (m == 1) check(c, ZC_T + 2);
    end
    @(posedge clock) dcm <= 0;
    wt(0, 1);
    @(posedge clock) valley_current_limit <= 1;
    repeat (30) @(negedge clock);
    check(high_gate_drive, 0);
    @(posedge clock) valley_current_limit <= 0;
    wt(0, 1);
    check(c, 7);
    @(posedge clock) fb_cmp <= 4'h8;
    wt(2, 0);
    check(c >= PGQ, 1);
    check(pg_pin, 1);
    w = 1 + $urandom % 200;
    @(posedge clock) fb_cmp <= 4'h4;
    repeat (w) @(posedge clock);
    fb_cmp <= 4'h8;
    @(negedge clock) check(power_good_flag_oe, 0);
    @(posedge clock) fb_cmp <= 4'h4;
    wt(2, 1);
    check(c >= 250 && c <= 254, 1);
    @(posedge clock) fb_cmp <= 4'h2;
    @(posedge clock) fb_cmp <= 4'h0;
    repeat (12) @(negedge clock);
    check({overvoltage_latch, high_gate_drive, low_gate_drive}, 3'h5);
    @(posedge clock) enable <= 0;
    repeat (3) @(negedge clock);
    check({overvoltage_latch, high_gate_drive, low_gate_drive, discharge_on}, 4'h1);
    @(posedge clock) begin
      enable <= 1;
      fb_cmp <= 4'h1;
    end
    wt(4, 1);
    check(c >= UVB + UVD - 2 && c <= UVB + UVD + 4, 1);
    @(posedge clock) begin
      supply_lockout <= 1;
      fb_cmp <= 4'h0;
    end
    repeat (3 + $urandom % 8) @(negedge clock);
    check({undervoltage_fault, high_gate_drive, low_gate_drive}, 3'h0);
    @(posedge clock) supply_lockout <= 0;
    wt(0, 1);
    check(high_gate_drive, 1);
    @(posedge clock) over_temp <= 1;
    repeat (4) @(negedge clock);
    check({high_gate_drive, low_gate_drive}, 2'h0);
    @(posedge clock) over_temp <= 0;
    wt(0, 1);
    check(high_gate_drive, 1);
    results;
  end
endmodule
